// >>> logic/ahds_pkg.sv
// Package: constants and types of the axis block
package ahds_pkg;
  // Parameter numbers on the command port
  localparam logic [7:0] PAR_SLOW_RUN = 8'hB7;
  localparam logic [7:0] PAR_RAND_OFF = 8'hB8;
  localparam logic [7:0] PAR_HOME_MODE = 8'hC1;
  localparam logic [7:0] PAR_COARSE_SPD = 8'hC2;
  localparam logic [7:0] PAR_FINE_SPD = 8'hC3;
  localparam logic [7:0] PAR_SWITCH_SPAN = 8'hC4;
  localparam logic [7:0] PAR_LAST_HOME = 8'hC5;
  localparam logic [7:0] PAR_BOOST = 8'hC8;
  localparam logic [7:0] PAR_FREEWHEEL = 8'hCC;
  localparam logic [7:0] PAR_LOAD = 8'hCE;
  localparam logic [7:0] PAR_EXT_ERROR = 8'hCF;
  localparam logic [7:0] PAR_DRV_STATUS = 8'hD0;
  localparam logic [7:0] PAR_GROUP = 8'hD5;
  localparam logic [7:0] PAR_STANDBY_DLY = 8'hD6;
  // Values after reset
  localparam logic [7:0] SLOW_RUN_RST = 8'h00;
  localparam logic [7:0] HOME_MODE_RST = 8'h01;
  localparam logic [10:0] SPEED_RST = 11'h000;
  localparam logic [7:0] BOOST_RST = 8'h00;
  localparam logic [15:0] FREEWHEEL_RST = 16'h0000;
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [15:0] STANDBY_DLY_RST = 16'h00C8;
  // Homing mode fields
  localparam int HOME_INV_BIT = 7;
  localparam int RIGHT_SEL_BIT = 6;
  localparam logic [5:0] MODE_LEFT_ONLY = 6'h01;
  localparam logic [5:0] MODE_RIGHT_LEFT = 6'h02;
  localparam logic [5:0] MODE_RIGHT_LEFT_BOTH = 6'h03;
  localparam logic [5:0] MODE_LEFT_BOTH = 6'h04;
  localparam logic [5:0] MODE_HOME_NEG_REV = 6'h05;
  localparam logic [5:0] MODE_HOME_POS_REV = 6'h06;
  localparam logic [5:0] MODE_HOME_POS = 6'h07;
  localparam logic [5:0] MODE_HOME_NEG = 6'h08;
  // Driver status bit positions
  localparam int ST_STALL = 0;
  localparam int ST_OVERTEMP = 1;
  localparam int ST_PREWARN = 2;
  localparam int ST_SHORT_A = 3;
  localparam int ST_SHORT_B = 4;
  localparam int ST_OPEN_A = 5;
  localparam int ST_OPEN_B = 6;
  localparam int ST_STANDSTILL = 7;
  // Timing: delay unit and standstill window
  localparam int CLK_MHZ = 200;
  localparam int DELAY_UNIT_MS = 10;
  localparam int TICK_CYCLES_DEF = DELAY_UNIT_MS * 1000 * CLK_MHZ;
  localparam int STANDSTILL_CYCLES_DEF = 1 << 20;
  // Motion commands
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ROTATE_RIGHT = 3'h1,
    CMD_ROTATE_LEFT = 3'h2,
    CMD_MOTOR_STOP = 3'h3,
    CMD_MOVE_TO_POSITION = 3'h4,
    CMD_REFERENCE_SEARCH = 3'h5
  } ahds_cmd_t;
  // Homing states, Gray along the search path
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_FIRST = 3'h1,
    HS_SEEK = 3'h3,
    HS_FINE = 3'h2,
    HS_BACK = 3'h6,
    HS_CLEAR = 3'h7
  } ahds_state_t;
endpackage : ahds_pkg

// >>> logic/ahds_axis_ctrl.sv
// Axis parameter set: current selection, homing sequencer, delays, status and grouping
`timescale 1ns/1ps
module ahds_axis_ctrl #(
  parameter int TICK_CYCLES = ahds_pkg::TICK_CYCLES_DEF,
  parameter int STANDSTILL_CYCLES = ahds_pkg::STANDSTILL_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Parameter command port
  input wire logic parCmdValid,
  input wire logic parCmdWrite,
  input wire logic [7:0] parCmdNum,
  input wire logic [31:0] parCmdData,
  output logic parRespValid,
  output logic [31:0] parRespData,
  output logic parRespRejected,
  // Motion commands for this axis and from other axes
  input wire logic motionCmdValid,
  input wire ahds_pkg::ahds_cmd_t motionCmdOp,
  input wire logic peerCmdValid,
  input wire ahds_pkg::ahds_cmd_t peerCmdOp,
  input wire logic [7:0] peerGroupIndex,
  output logic motionApplyValid,
  output ahds_pkg::ahds_cmd_t motionApplyOp,
  output logic [7:0] groupIndex,
  // Motion state and switches
  input wire logic [10:0] actualSpeed,
  input wire logic accelerating,
  input wire logic [31:0] actualPosition,
  input wire logic stepPulse,
  input wire logic leftStopSw,
  input wire logic rightStopSw,
  input wire logic homeSw,
  // Driver condition inputs
  input wire logic drvStall,
  input wire logic drvOverTemp,
  input wire logic drvPreWarn,
  input wire logic drvShortA,
  input wire logic drvShortB,
  input wire logic drvOpenA,
  input wire logic drvOpenB,
  input wire logic [9:0] loadValue,
  input wire logic stallError,
  // Current settings held outside this block
  input wire logic [7:0] maxCurrent,
  input wire logic [7:0] standbyCurrent,
  input wire logic [10:0] adaptThresholdSpeed,
  // Drive outputs
  output logic [7:0] coilCurrent,
  output logic adaptiveEnable,
  output logic chopperOffTimeRandom,
  output logic powerCut,
  output logic standbyActive,
  // Homing outputs
  output logic homingActive,
  output logic [10:0] homingSpeed,
  output logic homingDirPos,
  output logic positionClear
);

  // All block state
  typedef struct packed {
    logic [1:0] rstSync;
    logic [7:0] slowRun;
    logic randOff;
    logic [7:0] homeMode;
    logic [10:0] coarseSpd;
    logic [10:0] fineSpd;
    logic [31:0] span;
    logic [31:0] lastHome;
    logic [7:0] boost;
    logic [15:0] freeDelay;
    logic [9:0] load;
    logic errFlag;
    logic [7:0] status;
    logic [7:0] group;
    logic [15:0] standbyDelay;
    logic [31:0] tickCnt;
    logic [31:0] quietCnt;
    logic [15:0] idleUnits;
    ahds_pkg::ahds_state_t hState;
    logic dirPos;
    logic [31:0] rightPos;
    logic respValid;
    logic [31:0] respData;
    logic respRej;
    logic applyValid;
    ahds_pkg::ahds_cmd_t applyOp;
    logic [7:0] current;
    logic adaptEn;
    logic cut;
    logic standby;
    logic [10:0] hSpeed;
    logic posClr;
    logic hActive;
  } ahds_state_s_t;

  ahds_state_s_t s_r;
  ahds_state_s_t s_nxt;

  // Next-state logic
  always_comb begin
    logic [5:0] base;
    logic invHome;
    logic rightSel;
    logic stopMode;
    logic spanMode;
    logic bothSides;
    logic refSw;
    logic ownCmd;
    logic grpCmd;
    logic applyNow;
    ahds_pkg::ahds_cmd_t applyCmd;
    logic errClr;
    logic moving;
    logic tick;
    base = s_r.homeMode[5:0];
    invHome = s_r.homeMode[ahds_pkg::HOME_INV_BIT];
    rightSel = s_r.homeMode[ahds_pkg::RIGHT_SEL_BIT];
    stopMode = (base >= ahds_pkg::MODE_LEFT_ONLY) && (base <= ahds_pkg::MODE_LEFT_BOTH);
    spanMode = (base == ahds_pkg::MODE_RIGHT_LEFT) || (base == ahds_pkg::MODE_RIGHT_LEFT_BOTH);
    bothSides = (base == ahds_pkg::MODE_RIGHT_LEFT_BOTH) || (base == ahds_pkg::MODE_LEFT_BOTH);
    ownCmd = motionCmdValid && (motionCmdOp != ahds_pkg::CMD_NONE);
    grpCmd = peerCmdValid && (peerCmdOp != ahds_pkg::CMD_NONE) && (s_r.group != 8'h00)
      && (peerGroupIndex == s_r.group);
    applyNow = ownCmd || grpCmd;
    applyCmd = ownCmd ? motionCmdOp : peerCmdOp;
    errClr = 1'b0;
    moving = actualSpeed != 11'h000;
    tick = s_r.tickCnt >= 32'(TICK_CYCLES - 1);
    s_nxt = s_r;
    s_nxt.rstSync = {s_r.rstSync[0], 1'b1};
    // Reference switch: home with polarity, or stop switch
    if (stopMode) begin
      refSw = rightSel ? rightStopSw : leftStopSw;
    end else begin
      refSw = homeSw ^ invHome;
    end
    // One-cycle outputs default low
    s_nxt.respValid = 1'b0;
    s_nxt.respRej = 1'b0;
    s_nxt.applyValid = applyNow;
    s_nxt.applyOp = applyNow ? applyCmd : ahds_pkg::CMD_NONE;
    s_nxt.posClr = 1'b0;
    // Parameter access
    if (parCmdValid) begin
      s_nxt.respValid = 1'b1;
      s_nxt.respData = 32'h0;
      if (parCmdWrite) begin
        unique case (parCmdNum)
          ahds_pkg::PAR_SLOW_RUN: s_nxt.slowRun = parCmdData[7:0];
          ahds_pkg::PAR_RAND_OFF: s_nxt.randOff = parCmdData[0];
          ahds_pkg::PAR_HOME_MODE: s_nxt.homeMode = parCmdData[7:0];
          ahds_pkg::PAR_COARSE_SPD: s_nxt.coarseSpd = parCmdData[10:0];
          ahds_pkg::PAR_FINE_SPD: s_nxt.fineSpd = parCmdData[10:0];
          ahds_pkg::PAR_BOOST: s_nxt.boost = parCmdData[7:0];
          ahds_pkg::PAR_FREEWHEEL: s_nxt.freeDelay = parCmdData[15:0];
          ahds_pkg::PAR_GROUP: s_nxt.group = parCmdData[7:0];
          ahds_pkg::PAR_STANDBY_DLY: s_nxt.standbyDelay = parCmdData[15:0];
          // Read-only or unknown: nothing stored
          default: s_nxt.respRej = 1'b1;
        endcase
      end else begin
        unique case (parCmdNum)
          ahds_pkg::PAR_SLOW_RUN: s_nxt.respData = 32'(s_r.slowRun);
          ahds_pkg::PAR_RAND_OFF: s_nxt.respData = 32'(s_r.randOff);
          ahds_pkg::PAR_HOME_MODE: s_nxt.respData = 32'(s_r.homeMode);
          ahds_pkg::PAR_COARSE_SPD: s_nxt.respData = 32'(s_r.coarseSpd);
          ahds_pkg::PAR_FINE_SPD: s_nxt.respData = 32'(s_r.fineSpd);
          ahds_pkg::PAR_SWITCH_SPAN: s_nxt.respData = s_r.span;
          ahds_pkg::PAR_LAST_HOME: s_nxt.respData = s_r.lastHome;
          ahds_pkg::PAR_BOOST: s_nxt.respData = 32'(s_r.boost);
          ahds_pkg::PAR_FREEWHEEL: s_nxt.respData = 32'(s_r.freeDelay);
          ahds_pkg::PAR_LOAD: s_nxt.respData = 32'(s_r.load);
          ahds_pkg::PAR_EXT_ERROR: begin
            s_nxt.respData = 32'(s_r.errFlag);
            errClr = 1'b1;
          end
          ahds_pkg::PAR_DRV_STATUS: s_nxt.respData = 32'(s_r.status);
          ahds_pkg::PAR_GROUP: s_nxt.respData = 32'(s_r.group);
          ahds_pkg::PAR_STANDBY_DLY: s_nxt.respData = 32'(s_r.standbyDelay);
          default: s_nxt.respRej = 1'b1;
        endcase
      end
    end
    // Error flag: a stall in the clearing cycle still sets it
    if (applyNow) begin
      errClr = 1'b1;
    end
    s_nxt.errFlag = stallError | (s_r.errFlag & ~errClr);
    // Load readout follows the driver
    s_nxt.load = loadValue;
    // Standstill window counter, restarted by each step
    if (stepPulse) begin
      s_nxt.quietCnt = 32'h0;
    end else if (s_r.quietCnt < 32'(STANDSTILL_CYCLES)) begin
      s_nxt.quietCnt = s_r.quietCnt + 32'h1;
    end
    // Driver status snapshot
    s_nxt.status[ahds_pkg::ST_STALL] = drvStall;
    s_nxt.status[ahds_pkg::ST_OVERTEMP] = drvOverTemp;
    s_nxt.status[ahds_pkg::ST_PREWARN] = drvPreWarn;
    s_nxt.status[ahds_pkg::ST_SHORT_A] = drvShortA;
    s_nxt.status[ahds_pkg::ST_SHORT_B] = drvShortB;
    s_nxt.status[ahds_pkg::ST_OPEN_A] = drvOpenA;
    s_nxt.status[ahds_pkg::ST_OPEN_B] = drvOpenB;
    s_nxt.status[ahds_pkg::ST_STANDSTILL] = s_r.quietCnt >= 32'(STANDSTILL_CYCLES);
    // Delay unit prescaler and idle unit counter
    s_nxt.tickCnt = tick ? 32'h0 : s_r.tickCnt + 32'h1;
    if (moving) begin
      s_nxt.idleUnits = 16'h0000;
    end else if (tick && (s_r.idleUnits != 16'hFFFF)) begin
      s_nxt.idleUnits = s_r.idleUnits + 16'h0001;
    end
    s_nxt.cut = !moving && (s_r.freeDelay != 16'h0000) && (s_r.idleUnits >= s_r.freeDelay);
    s_nxt.standby = !moving && (s_r.idleUnits >= s_r.standbyDelay);
    // Current selection, highest priority first
    if (s_r.standby) begin
      s_nxt.current = standbyCurrent;
    end else if (accelerating) begin
      s_nxt.current = (s_r.boost == 8'h00) ? maxCurrent : s_r.boost;
    end else if (actualSpeed < adaptThresholdSpeed) begin
      s_nxt.current = s_r.slowRun;
    end else begin
      s_nxt.current = maxCurrent;
    end
    s_nxt.adaptEn = actualSpeed > adaptThresholdSpeed;
    // Homing sequencer
    unique case (s_r.hState)
      ahds_pkg::HS_IDLE: begin
        if (applyNow && (applyCmd == ahds_pkg::CMD_REFERENCE_SEARCH)) begin
          if (spanMode) begin
            s_nxt.hState = ahds_pkg::HS_FIRST;
            s_nxt.dirPos = 1'b1;
          end else begin
            s_nxt.hState = ahds_pkg::HS_SEEK;
            // Stop modes head for their switch
            s_nxt.dirPos = stopMode ? rightSel
              : ((base == ahds_pkg::MODE_HOME_POS_REV) || (base == ahds_pkg::MODE_HOME_POS));
          end
        end
      end
      ahds_pkg::HS_FIRST: begin
        // Right stop switch first, remember where it was
        if (rightStopSw) begin
          s_nxt.rightPos = actualPosition;
          s_nxt.hState = ahds_pkg::HS_SEEK;
          s_nxt.dirPos = rightSel;
        end
      end
      ahds_pkg::HS_SEEK: begin
        if (refSw) begin
          s_nxt.hState = ahds_pkg::HS_FINE;
          s_nxt.dirPos = !s_r.dirPos;
        end else if ((base == ahds_pkg::MODE_HOME_NEG_REV) && leftStopSw && !s_r.dirPos) begin
          s_nxt.dirPos = 1'b1;
        end else if ((base == ahds_pkg::MODE_HOME_POS_REV) && rightStopSw && s_r.dirPos) begin
          s_nxt.dirPos = 1'b0;
        end
      end
      ahds_pkg::HS_FINE: begin
        // Slowly leave the switch to find its edge
        if (!refSw) begin
          if (bothSides) begin
            s_nxt.hState = ahds_pkg::HS_BACK;
            s_nxt.dirPos = !s_r.dirPos;
          end else begin
            s_nxt.hState = ahds_pkg::HS_CLEAR;
          end
        end
      end
      ahds_pkg::HS_BACK: begin
        // Approach the edge again from the other side
        if (refSw) begin
          s_nxt.hState = ahds_pkg::HS_CLEAR;
        end
      end
      ahds_pkg::HS_CLEAR: begin
        s_nxt.lastHome = actualPosition;
        s_nxt.posClr = 1'b1;
        if (spanMode) begin
          s_nxt.span = s_r.rightPos - actualPosition;
        end
        s_nxt.hState = ahds_pkg::HS_IDLE;
      end
      default: s_nxt.hState = ahds_pkg::HS_IDLE;
    endcase
    // Any other command aborts the search
    if (applyNow && (applyCmd != ahds_pkg::CMD_REFERENCE_SEARCH) && (s_r.hState != ahds_pkg::HS_IDLE)) begin
      s_nxt.hState = ahds_pkg::HS_IDLE;
    end
    // Search speed per phase
    unique case (s_nxt.hState)
      ahds_pkg::HS_FIRST, ahds_pkg::HS_SEEK: s_nxt.hSpeed = s_r.coarseSpd;
      ahds_pkg::HS_FINE, ahds_pkg::HS_BACK: s_nxt.hSpeed = s_r.fineSpd;
      default: s_nxt.hSpeed = 11'h000;
    endcase
    s_nxt.hActive = s_nxt.hState != ahds_pkg::HS_IDLE;
    // Synchronous part of reset
    if (!s_r.rstSync[1]) begin
      s_nxt = '0;
      s_nxt.rstSync = {s_r.rstSync[0], 1'b1};
      s_nxt.slowRun = ahds_pkg::SLOW_RUN_RST;
      s_nxt.homeMode = ahds_pkg::HOME_MODE_RST;
      s_nxt.coarseSpd = ahds_pkg::SPEED_RST;
      s_nxt.fineSpd = ahds_pkg::SPEED_RST;
      s_nxt.boost = ahds_pkg::BOOST_RST;
      s_nxt.freeDelay = ahds_pkg::FREEWHEEL_RST;
      s_nxt.group = ahds_pkg::GROUP_RST;
      s_nxt.standbyDelay = ahds_pkg::STANDBY_DLY_RST;
    end
  end

  // State register; asynchronous reset clears everything
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign parRespValid = s_r.respValid;
  assign parRespData = s_r.respData;
  assign parRespRejected = s_r.respRej;
  assign motionApplyValid = s_r.applyValid;
  assign motionApplyOp = s_r.applyOp;
  assign groupIndex = s_r.group;
  assign coilCurrent = s_r.current;
  assign adaptiveEnable = s_r.adaptEn;
  assign chopperOffTimeRandom = s_r.randOff;
  assign powerCut = s_r.cut;
  assign standbyActive = s_r.standby;
  assign homingActive = s_r.hActive;
  assign homingSpeed = s_r.hSpeed;
  assign homingDirPos = s_r.dirPos;
  assign positionClear = s_r.posClr;

endmodule : ahds_axis_ctrl

// >>> testbench/ahds_axis_chk.sv
// Checker: port-level properties of the axis parameter block
`timescale 1ns/1ps
module ahds_axis_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Parameter port
  input wire logic parCmdValid,
  input wire logic parCmdWrite,
  input wire logic [7:0] parCmdNum,
  input wire logic parRespValid,
  input wire logic [31:0] parRespData,
  input wire logic parRespRejected,
  // Motion and grouping
  input wire logic motionCmdValid,
  input wire ahds_pkg::ahds_cmd_t motionCmdOp,
  input wire logic peerCmdValid,
  input wire ahds_pkg::ahds_cmd_t peerCmdOp,
  input wire logic [7:0] peerGroupIndex,
  input wire logic motionApplyValid,
  input wire ahds_pkg::ahds_cmd_t motionApplyOp,
  input wire logic [7:0] groupIndex,
  // Drive state
  input wire logic [10:0] actualSpeed,
  input wire logic [10:0] adaptThresholdSpeed,
  input wire logic stallError,
  input wire logic adaptiveEnable,
  input wire logic powerCut,
  input wire logic standbyActive,
  input wire logic homingActive,
  input wire logic positionClear
);
  // Edges since reset release, saturating
  logic [1:0] upCnt_r;
  // Counts out the reset synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upCnt_r <= 2'h0;
    end else if (upCnt_r != 2'h3) begin
      upCnt_r <= upCnt_r + 2'h1;
    end
  end
  // One clock domain
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ro_reject_a: assert property (parCmdValid && parCmdWrite && parCmdNum inside {8'hC4, 8'hC5, 8'hCE, 8'hCF, 8'hD0}
    |=> parRespValid && parRespRejected) else $error("ro write taken");
  adapt_speed_a: assert property (upCnt_r == 2'h3
    |-> adaptiveEnable == ($past(actualSpeed) > $past(adaptThresholdSpeed))) else $error("adapt wrong");
  own_apply_a: assert property (motionCmdValid && motionCmdOp != ahds_pkg::CMD_NONE
    |=> motionApplyValid && motionApplyOp == $past(motionCmdOp)) else $error("own cmd lost");
  group_zero_a: assert property (!motionCmdValid && peerCmdValid && groupIndex == 8'h00
    |=> !motionApplyValid) else $error("ungrouped took peer");
  group_match_a: assert property (!motionCmdValid && peerCmdValid && peerCmdOp != ahds_pkg::CMD_NONE
    && groupIndex != 8'h00 && peerGroupIndex == groupIndex |=> motionApplyValid && motionApplyOp == $past(peerCmdOp))
    else $error("group cmd lost");
  home_start_a: assert property (motionApplyValid && motionApplyOp == ahds_pkg::CMD_REFERENCE_SEARCH
    |-> homingActive) else $error("no homing");
  clear_once_a: assert property (positionClear |=> !positionClear ##[0:1] !homingActive)
    else $error("clear pulse wrong");
  motion_wake_a: assert property ((actualSpeed != 11'h000) [*2] |=> !powerCut && !standbyActive)
    else $error("power cut moving");
  stall_flag_a: assert property (stallError ##[1:3] (parCmdValid && !parCmdWrite && parCmdNum == 8'hCF)
    |=> parRespData == 32'h1) else $error("stall flag lost");
endmodule : ahds_axis_chk
bind ahds_axis_ctrl ahds_axis_chk chk (.*);

// >>> testbench/ahds_host_model.sv
// Host model: parameter requests and motion commands
`timescale 1ns/1ps
module ahds_host_model (
  // Clock
  input wire logic clk,
  // Parameter port
  output logic parCmdValid,
  output logic parCmdWrite,
  output logic [7:0] parCmdNum,
  output logic [31:0] parCmdData,
  input wire logic parRespValid,
  input wire logic [31:0] parRespData,
  input wire logic parRespRejected,
  // Own motion command
  output logic motionCmdValid,
  output ahds_pkg::ahds_cmd_t motionCmdOp
);
  // Idle values from time zero
  initial begin
    parCmdValid = 1'b0;
    parCmdWrite = 1'b0;
    parCmdNum = 8'h00;
    parCmdData = 32'hA5A5A5A5;
    motionCmdValid = 1'b0;
    motionCmdOp = ahds_pkg::CMD_NONE;
  end
  // One request; answer taken at the next falling edge
  task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic rej);
    @(negedge clk);
    parCmdValid = 1'b1;
    parCmdWrite = wr;
    parCmdNum = num;
    parCmdData = wdata;
    @(negedge clk);
    rdata = parRespValid ? parRespData : 'x;
    rej = parRespRejected;
    parCmdValid = 1'b0;
    // Released data differs from the last word
    parCmdData = ~wdata;
  endtask : access
  // One motion command pulse
  task automatic motion(input ahds_pkg::ahds_cmd_t op);
    @(negedge clk);
    motionCmdValid = 1'b1;
    motionCmdOp = op;
    @(negedge clk);
    motionCmdValid = 1'b0;
    motionCmdOp = ahds_pkg::CMD_NONE;
  endtask : motion
endmodule : ahds_host_model

// >>> testbench/axis_homing_and_drive_status_bench.sv
// Bench: directed scenarios for the axis parameter block
`timescale 1ns/1ps
module axis_homing_and_drive_status_bench;
  // Clock, reset, counters
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  int fails = 0;
  int checkCount = 0;
  // Host side nets
  logic parCmdValid, parCmdWrite, parRespValid, parRespRejected, motionCmdValid;
  logic [7:0] parCmdNum, groupIndex, coilCurrent;
  logic [31:0] parCmdData, parRespData;
  ahds_pkg::ahds_cmd_t motionCmdOp, motionApplyOp;
  ahds_pkg::ahds_cmd_t peerCmdOp = ahds_pkg::CMD_NONE;
  // Stimulus driven at falling edges
  logic peerCmdValid = 1'b0, accelerating = 1'b0, stepPulse = 1'b0, stepOn = 1'b0, stallError = 1'b0;
  logic leftStopSw = 1'b0, rightStopSw = 1'b0, homeSw = 1'b0;
  logic [6:0] drv = 7'h00;
  logic [7:0] peerGroupIndex = 8'h00;
  logic [9:0] loadValue = 10'h000;
  logic [10:0] actualSpeed = 11'h032, adaptThresholdSpeed = 11'h064, homingSpeed;
  logic [31:0] actualPosition = 32'h0;
  // Observed outputs
  logic motionApplyValid, adaptiveEnable, chopperOffTimeRandom, powerCut, standbyActive, homingActive;
  logic homingDirPos, positionClear;
  // 5 ns clock
  always #2.5 clk = ~clk;
  // Step pulses while enabled
  always @(negedge clk) stepPulse <= stepOn && !stepPulse;
  ahds_host_model host (.clk, .parCmdValid, .parCmdWrite, .parCmdNum, .parCmdData, .parRespValid,
    .parRespData, .parRespRejected, .motionCmdValid, .motionCmdOp);
  ahds_axis_ctrl #(.TICK_CYCLES(4), .STANDSTILL_CYCLES(16)) DUT (.clk, .arst_n, .parCmdValid, .parCmdWrite,
    .parCmdNum, .parCmdData, .parRespValid, .parRespData, .parRespRejected, .motionCmdValid, .motionCmdOp,
    .peerCmdValid, .peerCmdOp, .peerGroupIndex, .motionApplyValid, .motionApplyOp, .groupIndex, .actualSpeed,
    .accelerating, .actualPosition, .stepPulse, .leftStopSw, .rightStopSw, .homeSw, .drvStall(drv[0]),
    .drvOverTemp(drv[1]), .drvPreWarn(drv[2]), .drvShortA(drv[3]), .drvShortB(drv[4]), .drvOpenA(drv[5]),
    .drvOpenB(drv[6]), .loadValue, .stallError, .maxCurrent(8'h80), .standbyCurrent(8'h10), .adaptThresholdSpeed,
    .coilCurrent, .adaptiveEnable, .chopperOffTimeRandom, .powerCut, .standbyActive, .homingActive, .homingSpeed,
    .homingDirPos, .positionClear);
  // Falling edges to wait
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read and compare
  task automatic rd(input logic [7:0] num, input logic [31:0] exp);
    logic [31:0] d;
    logic r;
    host.access(1'b0, num, 32'h0, d, r);
    chk(d, exp);
  endtask : rd
  // Write and compare the refusal flag
  task automatic wt(input logic [7:0] num, input logic [31:0] data, input logic rej);
    logic [31:0] d;
    logic r;
    host.access(1'b1, num, data, d, r);
    chk(32'(r), 32'(rej));
  endtask : wt
  // Command issued to another axis
  task automatic peer(input ahds_pkg::ahds_cmd_t op, input logic [7:0] idx, input logic hit);
    @(negedge clk);
    peerCmdValid = 1'b1;
    peerCmdOp = op;
    peerGroupIndex = idx;
    @(negedge clk);
    peerCmdValid = 1'b0;
    peerGroupIndex = ~idx;
    chk(32'({motionApplyValid, motionApplyOp}), 32'({hit, hit ? op : ahds_pkg::CMD_NONE}));
  endtask : peer
  // Reset values, widths, read-only refusals
  task automatic test_regs;
    logic [7:0] num [9] = '{8'hB7, 8'hB8, 8'hC1, 8'hC2, 8'hC3, 8'hC8, 8'hCC, 8'hD5, 8'hD6};
    logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hC8};
    logic [31:0] mask [9] = '{32'hFF, 32'h1, 32'hFF, 32'h7FF, 32'h7FF, 32'hFF, 32'hFFFF, 32'hFF, 32'hFFFF};
    logic [7:0] ro [3] = '{8'hC4, 8'hC5, 8'hCE};
    logic [31:0] d;
    logic r;
    for (int i = 0; i < 9; i++) begin
      rd(num[i], rv[i]);
      wt(num[i], 32'hFFFFFFFF, 1'b0);
      rd(num[i], mask[i]);
    end
    for (int i = 0; i < 3; i++) begin
      host.access(1'b0, ro[i], 32'h0, d, r);
      wt(ro[i], 32'hFFFFFFFF, 1'b1);
      rd(ro[i], d);
    end
    wt(8'hCF, 32'h1, 1'b1);
    wt(8'hD0, 32'hFF, 1'b1);
    host.access(1'b0, 8'hB9, 32'h0, d, r);
    chk(32'(r), 32'h1);
    $display("test_regs done");
  endtask : test_regs
  // Current selection and off-time mode
  task automatic test_current;
    wt(8'hB7, 32'h40, 1'b0);
    cyc(2);
    chk(32'({adaptiveEnable, coilCurrent}), 32'h040);
    wt(8'hC8, 32'h0, 1'b0);
    accelerating = 1'b1;
    cyc(2);
    chk(32'(coilCurrent), 32'h80);
    wt(8'hC8, 32'h90, 1'b0);
    cyc(2);
    chk(32'(coilCurrent), 32'h90);
    accelerating = 1'b0;
    actualSpeed = 11'h096;
    cyc(2);
    chk(32'({adaptiveEnable, coilCurrent}), 32'h180);
    actualSpeed = 11'h064;
    cyc(2);
    chk(32'({adaptiveEnable, coilCurrent}), 32'h080);
    wt(8'hB8, 32'h0, 1'b0);
    cyc(2);
    chk(32'(chopperOffTimeRandom), 32'h0);
    wt(8'hB8, 32'h1, 1'b0);
    cyc(2);
    chk(32'(chopperOffTimeRandom), 32'h1);
    $display("test_current done");
  endtask : test_current
  // Driver status byte and load readout
  task automatic test_status;
    for (int i = 0; i < 7; i++) begin
      drv = 7'(1 << i);
      cyc(2);
      rd(8'hD0, 32'h80 | (32'h1 << i));
    end
    drv = 7'h00;
    loadValue = 10'h3FF;
    rd(8'hCE, 32'h3FF);
    stepOn = 1'b1;
    cyc(4);
    rd(8'hD0, 32'h0);
    stepOn = 1'b0;
    cyc(20);
    rd(8'hD0, 32'h80);
    $display("test_status done");
  endtask : test_status
  // Stall flag set, cleared by read and by motion
  task automatic test_error;
    for (int k = 0; k < 2; k++) begin
      stallError = 1'b1;
      cyc(1);
      stallError = 1'b0;
      if (k == 1) host.motion(ahds_pkg::CMD_MOTOR_STOP);
      if (k == 0) rd(8'hCF, 32'h1);
      rd(8'hCF, 32'h0);
    end
    $display("test_error done");
  endtask : test_error
  // Shared commands within a group
  task automatic test_group;
    wt(8'hD5, 32'h3, 1'b0);
    chk(32'(groupIndex), 32'h3);
    for (int op = 4; op > 0; op--) peer(ahds_pkg::ahds_cmd_t'(op), 8'h03, 1'b1);
    peer(ahds_pkg::CMD_ROTATE_LEFT, 8'h02, 1'b0);
    wt(8'hD5, 32'h0, 1'b0);
    peer(ahds_pkg::CMD_ROTATE_LEFT, 8'h00, 1'b0);
    $display("test_group done");
  endtask : test_group
  // Homing modes, then one full run with span
  task automatic test_homing;
    logic [7:0] mode [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h41, 8'h87};
    logic [7:0] dirs = 8'hD8;
    wt(8'hC2, 32'h200, 1'b0);
    wt(8'hC3, 32'h20, 1'b0);
    for (int i = 0; i < 8; i++) begin
      homeSw = mode[i][7];
      wt(8'hC1, 32'(mode[i]), 1'b0);
      host.motion(ahds_pkg::CMD_REFERENCE_SEARCH);
      chk(32'({homingActive, homingSpeed}), 32'hA00);
      chk(32'(homingDirPos), 32'(dirs[i]));
      if (mode[i] inside {[8'h05:8'h08]}) begin
        leftStopSw = (mode[i] != 8'h06);
        rightStopSw = (mode[i] != 8'h05);
        cyc(3);
        chk(32'(homingDirPos), 32'(dirs[i] ^ (mode[i] < 8'h07)));
        leftStopSw = 1'b0;
        rightStopSw = 1'b0;
      end
      host.motion(ahds_pkg::CMD_MOTOR_STOP);
      chk(32'(homingActive), 32'h0);
    end
    homeSw = 1'b0;
    actualPosition = 32'h3E8;
    wt(8'hC1, 32'h2, 1'b0);
    host.motion(ahds_pkg::CMD_REFERENCE_SEARCH);
    chk(32'(homingDirPos), 32'h1);
    rightStopSw = 1'b1;
    cyc(3);
    rightStopSw = 1'b0;
    actualPosition = 32'hFFFFFE0C;
    chk(32'({homingDirPos, homingSpeed}), 32'h200);
    leftStopSw = 1'b1;
    cyc(3);
    chk(32'({homingDirPos, homingSpeed}), 32'h820);
    leftStopSw = 1'b0;
    for (int n = 0; n < 20 && positionClear !== 1'b1; n++) cyc(1);
    chk(32'(positionClear), 32'h1);
    cyc(2);
    rd(8'hC5, 32'hFFFFFE0C);
    rd(8'hC4, 32'h5DC);
    $display("test_homing done");
  endtask : test_homing
  // Freewheel cut-off and standby entry
  task automatic test_power;
    wt(8'hCC, 32'h2, 1'b0);
    wt(8'hD6, 32'h3, 1'b0);
    actualSpeed = 11'h000;
    cyc(2);
    chk(32'({powerCut, standbyActive}), 32'h0);
    cyc(20);
    chk(32'({powerCut, standbyActive, coilCurrent}), 32'h310);
    actualSpeed = 11'h001;
    wt(8'hCC, 32'h0, 1'b0);
    actualSpeed = 11'h000;
    cyc(30);
    chk(32'({powerCut, standbyActive}), 32'h1);
    $display("test_power done");
  endtask : test_power
  // Counts and verdict, then stop
  task automatic summarize;
    $display("checks=%0d fails=%0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    cyc(5);
    arst_n = 1'b1;
    cyc(3);
    test_regs();
    test_current();
    test_status();
    test_error();
    test_group();
    test_homing();
    test_power();
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : axis_homing_and_drive_status_bench
